// file: design/pms_defines.vh
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define PMS_ADDR_W        12
`define PMS_DATA_W        32
`define PMS_FIELD_W       16
`define PMS_NUM_REGS      14
`define PMS_WE_LSB        16

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PMS_OFF_P8A_FUNC  12'h080
`define PMS_OFF_P8B_FUNC  12'h084
`define PMS_OFF_P1_UPPER  12'h104
`define PMS_OFF_P2_LOWER  12'h108
`define PMS_OFF_P2_UPPER  12'h10c
`define PMS_OFF_P3_LOWER  12'h110
`define PMS_OFF_P3_UPPER  12'h114
`define PMS_OFF_P4_LOWER  12'h118
`define PMS_OFF_P4_UPPER  12'h11c
`define PMS_OFF_P5_LOWER  12'h120
`define PMS_OFF_P5_UPPER  12'h124
`define PMS_OFF_P6_LOWER  12'h128
`define PMS_OFF_P6_UPPER  12'h12c
`define PMS_OFF_P7_LOWER  12'h130

// ----------------------------------------
// Reset values of the low halves
// ----------------------------------------
`define PMS_RST_ZERO      16'h0000
`define PMS_RST_P1_UPPER  16'h0f00
`define PMS_RST_P3_LOWER  16'h20ff
`define PMS_RST_P3_UPPER  16'hff04
`define PMS_RST_P4_LOWER  16'h0120
`define PMS_RST_P6_LOWER  16'h0100
`define PMS_RST_P6_UPPER  16'h0010

// ----------------------------------------
// Implemented bits (reserved bits are zero)
// ----------------------------------------
`define PMS_IMP_P8A       16'h001f
`define PMS_IMP_P8B       16'h000f
`define PMS_IMP_HIGH      16'hff00
`define PMS_IMP_LOW       16'h00ff
`define PMS_IMP_FULL      16'hffff

// ----------------------------------------
// Function selector codes
// ----------------------------------------
`define PMS_SEL_GPIO      2'b00
`define PMS_SEL_ALT1      2'b01
`define PMS_SEL_ALT2      2'b10

`endif

// file: design/pms_mask_reg.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// One bank register with per-bit write mask
// ----------------------------------------
module pms_mask_reg #(
  parameter [15:0] RESET_VAL = 16'h0000,
  parameter [15:0] IMPL_MASK = 16'hffff
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        wrEn,
  input  wire [31:0] wrData,
  output wire [15:0] fieldVal,
  output wire [15:0] fieldNext
);

  reg  [15:0] field_reg;
  wire [15:0] bitWe;

  // Upper half gates the lower half bit by bit; reserved bits never open
  assign bitWe     = wrEn ? (wrData[31:16] & IMPL_MASK) : 16'h0000;
  assign fieldNext = (field_reg & ~bitWe) | (wrData[15:0] & bitWe);  // [R1] [R8] [R15]
  assign fieldVal  = field_reg;

  // Field storage, new value one cycle after the write
  always @(posedge clk) begin
    if (!resetn) begin
      field_reg <= RESET_VAL & IMPL_MASK;
    end else begin
      field_reg <= fieldNext;  // [R18]
    end
  end

endmodule // pms_mask_reg

`default_nettype wire

// file: design/pms_addr_decode.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Address to one-hot register select
// ----------------------------------------
module pms_addr_decode #(
  parameter NUM_REGS = 14,
  parameter ADDR_W   = 12,
  parameter [NUM_REGS*ADDR_W-1:0] ADDR_TABLE = {NUM_REGS*ADDR_W{1'b0}}
) (
  input  wire [ADDR_W-1:0]   addr,
  output wire [NUM_REGS-1:0] hit
);

  genvar i;

  // Exact word match; anything else selects nothing
  generate
    for (i = 0; i < NUM_REGS; i = i + 1) begin : gCmp
      assign hit[i] = (addr == ADDR_TABLE[i*ADDR_W +: ADDR_W]);
    end
  endgenerate

endmodule // pms_addr_decode

`default_nettype wire

// file: design/pms_bank.v
// Summary of operation
// R1: Upper bit n+16 enables write of bit n
// R2: Speed bit zero slow, one fast edges
// R3: Port 8A bit 4: gpio or card detect
// R4: Port 8A pin 1: gpio, PS/2 data, 3.3V
// R5: Port 8A pin 0: gpio, PS/2 clock, 1.8V
// R6: Port 8B pin 1: gpio, serial transmit, clock
// R7: Port 8B pin 0: gpio, serial receive, reset
// R8: Port 8B bits 15:4 read zero, fixed
// R9: Port 1D speed resets to 0x0f
// R10: Port 3B resets 0x20, 3A 0xff
// R11: Port 3D resets 0xff, 3C 0x04
// R12: Port 4B resets 0x01, 4A 0x20
// R13: Port 6B resets 0x01, 6A zero
// R14: Only port 6C implemented, resets 0x10
// R15: Listed reserved speed bytes read zero
// R16: Other listed speed fields reset zero
// R17: Write-enable half always reads zero
// R18: Fields drive pads, update next cycle
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.vh"

module pms_bank #(
  parameter NUM_REGS = `PMS_NUM_REGS,
  parameter ADDR_W   = `PMS_ADDR_W
) (
  input  wire              clk,
  input  wire              resetn,
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [31:0]       regWrData,
  input  wire              regWrStb,
  input  wire              regRdStb,
  output wire [31:0]       regRdData,
  output wire              port8aPin2Function,
  output wire [1:0]        port8aPin1Function,
  output wire [1:0]        port8aPin0Function,
  output wire [1:0]        port8bPin1Function,
  output wire [1:0]        port8bPin0Function,
  output wire              smartcardDetectAltEn,
  output wire              ps2DataEn,
  output wire              smartcardSupply3v3CtlEn,
  output wire              ps2ClockEn,
  output wire              smartcardSupply1v8CtlEn,
  output wire              serialPort2TransmitEn,
  output wire              smartcardClockEn,
  output wire              serialPort2ReceiveEn,
  output wire              smartcardResetEn,
  output wire [7:0]        port1dEdgeSpeed,
  output wire [7:0]        port2aEdgeSpeed,
  output wire [7:0]        port2bEdgeSpeed,
  output wire [7:0]        port2cEdgeSpeed,
  output wire [7:0]        port3aEdgeSpeed,
  output wire [7:0]        port3bEdgeSpeed,
  output wire [7:0]        port3cEdgeSpeed,
  output wire [7:0]        port3dEdgeSpeed,
  output wire [7:0]        port4aEdgeSpeed,
  output wire [7:0]        port4bEdgeSpeed,
  output wire [7:0]        port4cEdgeSpeed,
  output wire [7:0]        port4dEdgeSpeed,
  output wire [7:0]        port5bEdgeSpeed,
  output wire [7:0]        port5cEdgeSpeed,
  output wire [7:0]        port6aEdgeSpeed,
  output wire [7:0]        port6bEdgeSpeed,
  output wire [7:0]        port6cEdgeSpeed,
  output wire [7:0]        port7aEdgeSpeed,
  output wire [7:0]        port7bEdgeSpeed
);

  // ----------------------------------------
  // Register index map
  // ----------------------------------------
  // Function selector registers
  localparam IX_P8A = 0;
  localparam IX_P8B = 1;

  // Speed registers in address order
  localparam IX_P1H = 2;
  localparam IX_P2L = 3;
  localparam IX_P2H = 4;
  localparam IX_P3L = 5;
  localparam IX_P3H = 6;
  localparam IX_P4L = 7;
  localparam IX_P4H = 8;
  localparam IX_P5L = 9;
  localparam IX_P5H = 10;
  localparam IX_P6L = 11;
  localparam IX_P6H = 12;
  localparam IX_P7L = 13;

  // Byte offsets, index 0 in the low slice
  localparam [14*12-1:0] ADDR_TABLE = {
    `PMS_OFF_P7_LOWER,
    `PMS_OFF_P6_UPPER,
    `PMS_OFF_P6_LOWER,
    `PMS_OFF_P5_UPPER,
    `PMS_OFF_P5_LOWER,
    `PMS_OFF_P4_UPPER,
    `PMS_OFF_P4_LOWER,
    `PMS_OFF_P3_UPPER,
    `PMS_OFF_P3_LOWER,
    `PMS_OFF_P2_UPPER,
    `PMS_OFF_P2_LOWER,
    `PMS_OFF_P1_UPPER,
    `PMS_OFF_P8B_FUNC,
    `PMS_OFF_P8A_FUNC
  };

  // Reset values of every low half
  localparam [14*16-1:0] RESET_TABLE = {
    `PMS_RST_ZERO,                           // Ports 7A/7B [R16]
    `PMS_RST_P6_UPPER,                       // Port 6C [R14]
    `PMS_RST_P6_LOWER,                       // Ports 6B/6A [R13]
    `PMS_RST_ZERO,                           // Port 5C [R16]
    `PMS_RST_ZERO,                           // Port 5B [R16]
    `PMS_RST_ZERO,                           // Ports 4D/4C [R16]
    `PMS_RST_P4_LOWER,                       // Ports 4B/4A [R12]
    `PMS_RST_P3_UPPER,                       // Ports 3D/3C [R11]
    `PMS_RST_P3_LOWER,                       // Ports 3B/3A [R10]
    `PMS_RST_ZERO,                           // Port 2C [R16]
    `PMS_RST_ZERO,                           // Ports 2B/2A [R16]
    `PMS_RST_P1_UPPER,                       // Port 1D [R9]
    `PMS_RST_ZERO,                           // Port 8B selectors [R6] [R7]
    `PMS_RST_ZERO                            // Port 8A selectors [R3]
  };

  // Implemented bits; the rest read zero and ignore writes
  localparam [14*16-1:0] IMPL_TABLE = {
    `PMS_IMP_FULL,
    `PMS_IMP_LOW,                            // Upper byte reserved [R14] [R15]
    `PMS_IMP_FULL,
    `PMS_IMP_LOW,                            // Upper byte reserved [R15]
    `PMS_IMP_HIGH,                           // Lower byte reserved [R15]
    `PMS_IMP_FULL,
    `PMS_IMP_FULL,
    `PMS_IMP_FULL,
    `PMS_IMP_FULL,
    `PMS_IMP_LOW,                            // Upper byte reserved [R15]
    `PMS_IMP_FULL,
    `PMS_IMP_HIGH,                           // Lower byte reserved [R9]
    `PMS_IMP_P8B,                            // Bits 15:4 reserved [R8]
    `PMS_IMP_P8A
  };

  // ----------------------------------------
  // Selector decode helper
  // ----------------------------------------
  // Code 11 is reserved and behaves like gpio: no alternate enable
  function selIs;
    input [1:0] code;
    input [1:0] want;
    begin
      selIs = (code == want);
    end
  endfunction

  // ----------------------------------------
  // Bus decode and register cells
  // ----------------------------------------
  wire [NUM_REGS-1:0]    regHit;
  wire [NUM_REGS*16-1:0] fieldAll;
  wire [NUM_REGS*16-1:0] nextAll;
  wire [NUM_REGS-1:0]    regWrHit;

  pms_addr_decode #(
    .NUM_REGS   (NUM_REGS),
    .ADDR_W     (ADDR_W),
    .ADDR_TABLE (ADDR_TABLE)
  ) uDecode (
    .addr (regAddr),
    .hit  (regHit)
  );

  // Write strobe qualified per register; unmapped addresses open no cell
  assign regWrHit = regHit & {NUM_REGS{regWrStb}};  // [R1]

  genvar i;

  // One masked cell per register; unmapped writes reach no cell
  generate
    for (i = 0; i < NUM_REGS; i = i + 1) begin : gReg
      pms_mask_reg #(
        .RESET_VAL (RESET_TABLE[i*16 +: 16]),
        .IMPL_MASK (IMPL_TABLE[i*16 +: 16])
      ) uCell (
        .clk       (clk),
        .resetn    (resetn),
        .wrEn      (regWrHit[i]),  // [R1]
        .wrData    (regWrData),
        .fieldVal  (fieldAll[i*16 +: 16]),
        .fieldNext (nextAll[i*16 +: 16])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg  [31:0] rdData_reg;
  reg  [15:0] rdMux;
  integer     k;

  // OR of the selected cell; reserved bits are already zero in the cells
  always @* begin
    rdMux = 16'h0000;
    for (k = 0; k < NUM_REGS; k = k + 1) begin
      if (regHit[k]) begin
        rdMux = rdMux | fieldAll[k*16 +: 16];
      end
    end
  end

  // Data valid only in the cycle after the strobe; mask half reads zero
  always @(posedge clk) begin
    if (!resetn) begin
      rdData_reg <= 32'h00000000;
    end else if (regRdStb) begin
      rdData_reg <= {16'h0000, rdMux};  // [R17]
    end else begin
      rdData_reg <= 32'h00000000;
    end
  end

  assign regRdData = rdData_reg;

  // ----------------------------------------
  // Port 8 function selectors
  // ----------------------------------------
  wire [15:0] p8aVal  = fieldAll[IX_P8A*16 +: 16];
  wire [15:0] p8bVal  = fieldAll[IX_P8B*16 +: 16];
  wire [15:0] p8aNext = nextAll[IX_P8A*16 +: 16];
  wire [15:0] p8bNext = nextAll[IX_P8B*16 +: 16];

  // Port 8A raw selector codes straight from the cell
  assign port8aPin2Function = p8aVal[4];    // [R3]
  assign port8aPin1Function = p8aVal[3:2];  // [R4]
  assign port8aPin0Function = p8aVal[1:0];  // [R5]

  // Port 8B raw selector codes; bits 15:4 of the cell are never stored
  assign port8bPin1Function = p8bVal[3:2];  // [R6]
  assign port8bPin0Function = p8bVal[1:0];  // [R7]

  // ----------------------------------------
  // Alternate function enables
  // ----------------------------------------
  reg [8:0] altEn_reg;
  reg [8:0] altEn_next;

  // Decoded from the cell's next value so enables track the field exactly
  always @* begin
    altEn_next[0] = p8aNext[4];                               // [R3]
    altEn_next[1] = selIs(p8aNext[3:2], `PMS_SEL_ALT1);       // [R4]
    altEn_next[2] = selIs(p8aNext[3:2], `PMS_SEL_ALT2);       // [R4]
    altEn_next[3] = selIs(p8aNext[1:0], `PMS_SEL_ALT1);       // [R5]
    altEn_next[4] = selIs(p8aNext[1:0], `PMS_SEL_ALT2);       // [R5]
    altEn_next[5] = selIs(p8bNext[3:2], `PMS_SEL_ALT1);       // [R6]
    altEn_next[6] = selIs(p8bNext[3:2], `PMS_SEL_ALT2);       // [R6]
    altEn_next[7] = selIs(p8bNext[1:0], `PMS_SEL_ALT1);       // [R7]
    altEn_next[8] = selIs(p8bNext[1:0], `PMS_SEL_ALT2);       // [R7]
  end

  // Registered so pad logic sees glitch-free levels
  always @(posedge clk) begin
    if (!resetn) begin
      altEn_reg <= 9'h000;
    end else begin
      altEn_reg <= altEn_next;  // [R18]
    end
  end

  // Port 8A enables, one per alternate signal
  assign smartcardDetectAltEn    = altEn_reg[0];
  assign ps2DataEn               = altEn_reg[1];
  assign smartcardSupply3v3CtlEn = altEn_reg[2];
  assign ps2ClockEn              = altEn_reg[3];
  assign smartcardSupply1v8CtlEn = altEn_reg[4];

  // Port 8B enables; reserved code 11 leaves the pin on gpio
  assign serialPort2TransmitEn   = altEn_reg[5];
  assign smartcardClockEn        = altEn_reg[6];
  assign serialPort2ReceiveEn    = altEn_reg[7];
  assign smartcardResetEn        = altEn_reg[8];

  // ----------------------------------------
  // Pad edge speed fields
  // ----------------------------------------
  // Each bit drives one pad: 0 slow (half rate) edges, 1 fast edges [R2]
  // Taken straight from the cell flops, so pads never see decode glitches

  // ----------------------------------------
  // Ports 1 and 2
  // ----------------------------------------
  // Port 1D sits in the upper byte; the low byte is reserved
  assign port1dEdgeSpeed = fieldAll[IX_P1H*16+8 +: 8];  // [R9]
  // Port 2 has fields for 2A, 2B and 2C only
  assign port2aEdgeSpeed = fieldAll[IX_P2L*16   +: 8];  // [R16]
  assign port2bEdgeSpeed = fieldAll[IX_P2L*16+8 +: 8];  // [R16]
  assign port2cEdgeSpeed = fieldAll[IX_P2H*16   +: 8];  // [R15] [R16]

  // ----------------------------------------
  // Port 3
  // ----------------------------------------
  // Both halves fully implemented, all with nonzero defaults
  assign port3aEdgeSpeed = fieldAll[IX_P3L*16   +: 8];  // [R10]
  assign port3bEdgeSpeed = fieldAll[IX_P3L*16+8 +: 8];  // [R10]
  assign port3cEdgeSpeed = fieldAll[IX_P3H*16   +: 8];  // [R11]
  assign port3dEdgeSpeed = fieldAll[IX_P3H*16+8 +: 8];  // [R11]

  // ----------------------------------------
  // Port 4
  // ----------------------------------------
  // 4A and 4B reset nonzero; 4C and 4D reset to slow edges
  assign port4aEdgeSpeed = fieldAll[IX_P4L*16   +: 8];  // [R12]
  assign port4bEdgeSpeed = fieldAll[IX_P4L*16+8 +: 8];  // [R12]
  assign port4cEdgeSpeed = fieldAll[IX_P4H*16   +: 8];  // [R16]
  assign port4dEdgeSpeed = fieldAll[IX_P4H*16+8 +: 8];

  // ----------------------------------------
  // Port 5
  // ----------------------------------------
  // Only 5B and 5C exist; the 5A and 5D bytes read zero
  assign port5bEdgeSpeed = fieldAll[IX_P5L*16+8 +: 8];  // [R16]
  assign port5cEdgeSpeed = fieldAll[IX_P5H*16   +: 8];  // [R16]

  // ----------------------------------------
  // Port 6
  // ----------------------------------------
  // 6C alone is implemented in the upper half
  assign port6aEdgeSpeed = fieldAll[IX_P6L*16   +: 8];  // [R13]
  assign port6bEdgeSpeed = fieldAll[IX_P6L*16+8 +: 8];  // [R13]
  assign port6cEdgeSpeed = fieldAll[IX_P6H*16   +: 8];  // [R14]

  // ----------------------------------------
  // Port 7
  // ----------------------------------------
  // Lower half only: both bytes writable, both reset to slow edges
  assign port7aEdgeSpeed = fieldAll[IX_P7L*16   +: 8];  // [R16]
  assign port7bEdgeSpeed = fieldAll[IX_P7L*16+8 +: 8];  // [R16]

endmodule // pms_bank

`default_nettype wire

// file: dv/pms_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the bank
// ----------------------------------------
module pms_bank_chk #(
  parameter ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWrStb,
  input wire logic              regRdStb,
  input wire logic [31:0]       regRdData,
  input wire logic              port8aPin2Function,
  input wire logic [1:0]        port8aPin1Function,
  input wire logic [1:0]        port8bPin1Function,
  input wire logic              smartcardDetectAltEn,
  input wire logic              ps2DataEn,
  input wire logic              smartcardSupply3v3CtlEn,
  input wire logic              serialPort2TransmitEn,
  input wire logic              smartcardClockEn,
  input wire logic [7:0]        port1dEdgeSpeed,
  input wire logic [7:0]        port3aEdgeSpeed,
  input wire logic [7:0]        port3bEdgeSpeed,
  input wire logic [7:0]        port3cEdgeSpeed
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_mask_half:
    assert property (regRdStb |=> regRdData[31:16] == 16'h0000)
    else $error("Mask half read back nonzero");
  chk_p8b_resv:
    assert property (regRdStb && regAddr == 12'h084 |=> regRdData[15:4] == 12'h000)
    else $error("Reserved function bits read nonzero");
  chk_p1_resv:
    assert property (regRdStb && regAddr == 12'h104 |=> regRdData[7:0] == 8'h00)
    else $error("Reserved speed byte read nonzero");
  chk_wr_update:
    assert property (regWrStb && regAddr == 12'h110 && regWrData[23:16] == 8'hff
                     |=> port3aEdgeSpeed == $past(regWrData[7:0]))
    else $error("Enabled speed bits not taken");
  chk_wr_masked:
    assert property (regWrStb && regAddr == 12'h110 && regWrData[31:24] == 8'h00
                     |=> $stable(port3bEdgeSpeed))
    else $error("Masked speed bits changed");
  chk_idle_hold:
    assert property (!regWrStb |=> $stable(port3aEdgeSpeed))
    else $error("Speed field moved without a write");
  chk_reset_vals:
    assert property ($rose(resetn) |-> port1dEdgeSpeed == 8'h0f && port3cEdgeSpeed == 8'h04)
    else $error("Speed defaults wrong after reset");
  chk_p8a_decode:
    assert property (smartcardDetectAltEn == port8aPin2Function
                     && ps2DataEn == (port8aPin1Function == 2'b01)
                     && smartcardSupply3v3CtlEn == (port8aPin1Function == 2'b10))
    else $error("Port 8A enables disagree with codes");
  chk_p8b_decode:
    assert property (serialPort2TransmitEn == (port8bPin1Function == 2'b01)
                     && smartcardClockEn == (port8bPin1Function == 2'b10))
    else $error("Port 8B enables disagree with codes");
endmodule // pms_bank_chk

bind pms_bank pms_bank_chk #(.ADDR_W(ADDR_W)) i_chk (
  .clk, .resetn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
  .port8aPin2Function, .port8aPin1Function, .port8bPin1Function,
  .smartcardDetectAltEn, .ps2DataEn, .smartcardSupply3v3CtlEn,
  .serialPort2TransmitEn, .smartcardClockEn,
  .port1dEdgeSpeed, .port3aEdgeSpeed, .port3bEdgeSpeed, .port3cEdgeSpeed
);
`default_nettype wire

// file: dv/pms_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Register bank bench
// ----------------------------------------
module testbench;
  logic        clk;
  logic        resetn;
  logic [11:0] regAddr;
  logic [31:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  wire  [31:0] regRdData;
  wire  [1:0]  f8a1, f8a0, f8b1, f8b0;
  wire         f8a2, enDet, enPs2D, en33, enPs2C, en18, enTx, enScClk, enRx, enScRst;
  wire  [151:0] spAll;
  wire  [7:0]  sp1d = spAll[7:0];
  wire  [7:0]  sp3a = spAll[39:32];
  wire  [7:0]  sp3b = spAll[47:40];
  int          bad_count;
  int          n_compared;
  int          cycles;
  int          i;
  logic [1:0]  c;
  // Map, reset values and implemented bits, index for index
  logic [11:0] addrT [14] = '{12'h080, 12'h084, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h114,
                              12'h118, 12'h11c, 12'h120, 12'h124, 12'h128, 12'h12c, 12'h130};
  logic [15:0] rstT  [14] = '{16'h0000, 16'h0000, 16'h0f00, 16'h0000, 16'h0000, 16'h20ff, 16'hff04,
                              16'h0120, 16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0010, 16'h0000};
  logic [15:0] impT  [14] = '{16'h001f, 16'h000f, 16'hff00, 16'hffff, 16'h00ff, 16'hffff, 16'hffff,
                              16'hffff, 16'hffff, 16'hff00, 16'h00ff, 16'hffff, 16'h00ff, 16'hffff};
  // Speed outputs after reset, 1D first and 7B last
  logic [7:0]  spRstT [19] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'hff, 8'h20, 8'h04, 8'hff, 8'h20, 8'h01,
                              8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h10, 8'h00, 8'h00};

  pms_bank i_pms_bank (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .port8aPin2Function(f8a2), .port8aPin1Function(f8a1), .port8aPin0Function(f8a0),
    .port8bPin1Function(f8b1), .port8bPin0Function(f8b0),
    .smartcardDetectAltEn(enDet), .ps2DataEn(enPs2D), .smartcardSupply3v3CtlEn(en33),
    .ps2ClockEn(enPs2C), .smartcardSupply1v8CtlEn(en18), .serialPort2TransmitEn(enTx),
    .smartcardClockEn(enScClk), .serialPort2ReceiveEn(enRx), .smartcardResetEn(enScRst),
    .port1dEdgeSpeed(spAll[7:0]), .port2aEdgeSpeed(spAll[15:8]), .port2bEdgeSpeed(spAll[23:16]),
    .port2cEdgeSpeed(spAll[31:24]), .port3aEdgeSpeed(spAll[39:32]), .port3bEdgeSpeed(spAll[47:40]),
    .port3cEdgeSpeed(spAll[55:48]), .port3dEdgeSpeed(spAll[63:56]), .port4aEdgeSpeed(spAll[71:64]),
    .port4bEdgeSpeed(spAll[79:72]), .port4cEdgeSpeed(spAll[87:80]), .port4dEdgeSpeed(spAll[95:88]),
    .port5bEdgeSpeed(spAll[103:96]), .port5cEdgeSpeed(spAll[111:104]), .port6aEdgeSpeed(spAll[119:112]),
    .port6bEdgeSpeed(spAll[127:120]), .port6cEdgeSpeed(spAll[135:128]), .port7aEdgeSpeed(spAll[143:136]),
    .port7bEdgeSpeed(spAll[151:144])
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hang short; the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; fields are settled just after the taking edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    resetn     = 1'b0;
    regAddr    = 12'h000;
    regWrData  = 32'h00000000;
    regWrStb   = 1'b0;
    regRdStb   = 1'b0;
    bad_count  = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Defaults of every register
    for (i = 0; i < 14; i++) rd(addrT[i], {16'h0000, rstT[i]});
    chk(sp1d, 8'h0f);
    for (i = 0; i < 19; i++) chk(spAll[i*8 +: 8], spRstT[i]);
    // All ones, then data without enables, then enables with zero data
    for (i = 0; i < 14; i++) begin
      wr(addrT[i], 32'hffffffff);
      rd(addrT[i], {16'h0000, impT[i]});
      wr(addrT[i], 32'h0000ffff);
      rd(addrT[i], {16'h0000, impT[i]});
      wr(addrT[i], 32'hffff0000);
      rd(addrT[i], 32'h00000000);
    end
    // Every speed output follows its cleared field
    for (i = 0; i < 19; i++) chk(spAll[i*8 +: 8], 8'h00);
    // Partial masks on a shared register
    wr(12'h110, 32'h00ff0012);
    chk(sp3a, 8'h12);
    chk(sp3b, 8'h00);
    wr(12'h110, 32'h8000ffff);
    rd(12'h110, 32'h00008012);
    // Every selector code, the reserved one included
    for (i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(12'h080, {16'h001f, 11'h000, c[0], c, c});
      wr(12'h084, {16'h000f, 12'h000, c, c});
      chk({f8a2, f8a1, f8a0, f8b1, f8b0}, {c[0], c, c, c, c});
      chk({enDet, enPs2D, en33, enPs2C, en18}, {c[0], c==2'b01, c==2'b10, c==2'b01, c==2'b10});
      chk({enTx, enScClk, enRx, enScRst}, {c == 2'b01, c == 2'b10, c == 2'b01, c == 2'b10});
      rd(12'h084, {28'h0000000, c, c});
    end
    // Unmapped place is ignored and reads zero
    wr(12'h200, 32'hffffffff);
    rd(12'h200, 32'h00000000);
    rd(12'h110, 32'h00008012);
    // Reset in mid-run brings the defaults back
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(12'h110, 32'h000020ff);
    rd(12'h104, 32'h00000f00);
    for (i = 0; i < 19; i++) chk(spAll[i*8 +: 8], spRstT[i]);
    stop_test;
  end
endmodule // testbench
`default_nettype wire
